/* pcds_pkg.sv */
// constants and widths shared by the column data shifter
//------------------------------------------------------------
// How it works
//------------------------------------------------------------
// How it works
// - Two 16-stage chains shift together, one stage per falling edge of the shift clock.
// - The even chain loads stage 2 from the even serial input and moves up to stage 32.
// - The odd chain loads stage 1 from the odd serial input and moves up to stage 31.
// - Without a falling shift clock edge the shift stages keep their contents.
// - While the transfer gate is high each of the 32 hold stages follows its shift stage.
// - When the transfer gate falls the hold stages keep their value while it stays low.
// - With force high and permit high every line output is on.
// - With force low and permit high each line output follows its hold stage.
// - With permit low all 32 line outputs are off, overriding force and hold stages.
// - The cascade outputs show stages 31 and 32, independent of gate, force and permit.
package pcds_pkg;
    localparam int          NUM_LINES    = 32;
    localparam int          CHAIN_LEN    = 16;
    localparam int          PAIR_W       = 2;
    localparam int          FIFO_DEPTH   = 8;
    localparam int          ODD_BIT      = 0;
    localparam int          EVEN_BIT     = 1;
    localparam int          CHAIN_STEP   = 2;
    localparam int          LAST_ODD     = 30;
    localparam int          LAST_EVEN    = 31;
    localparam logic [31:0] LINES_OFF    = 32'h0000_0000;
    localparam logic [31:0] LINES_ON     = 32'hffff_ffff;
    localparam logic [31:0] STAGE_RST    = 32'h0000_0000;
endpackage : pcds_pkg

/* pcds_fifo_if.sv */
// valid/ready carrier between the pair buffer and the shifter
`timescale 1ns/10ps
`default_nettype none
interface pcds_fifo_if #(parameter int WIDTH = 2);
    logic             inValid;
    logic             inReady;
    logic [WIDTH-1:0] inData;
    logic             outValid;
    logic             outReady;
    logic [WIDTH-1:0] outData;
    modport src  (output inValid, output inData, input inReady);
    modport fifo (input inValid, input inData, output inReady,
                  output outValid, output outData, input outReady);
    modport snk  (input outValid, input outData, output outReady);
endinterface : pcds_fifo_if
`default_nettype wire

/* pcds_fifo.sv */
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module pcds_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 8
) (
    input wire logic  clk,
    input wire logic  rstN,
    pcds_fifo_if.fifo q
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
    localparam logic [AW:0]   FULL_CNT = (AW + 1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wrPtr;
        logic [AW-1:0]               rdPtr;
        logic [AW:0]                 count;
        logic                        notFull;
    } pcds_fifo_s;

    localparam pcds_fifo_s RST_ST = '{mem: '0, wrPtr: '0, rdPtr: '0, count: '0, notFull: 1'b1};

    pcds_fifo_s st;
    pcds_fifo_s next_st;
    logic       push;
    logic       pop;

    //--------------------------------------------------------
    // next state
    //--------------------------------------------------------
    always_comb begin
        next_st = st;
        push    = q.inValid & st.notFull;
        pop     = (st.count != '0) & q.outReady;
        if (push) begin
            next_st.mem[st.wrPtr] = q.inData;
            next_st.wrPtr = (st.wrPtr == LAST_PTR) ? '0 : st.wrPtr + 1'b1;
        end
        if (pop) begin
            next_st.rdPtr = (st.rdPtr == LAST_PTR) ? '0 : st.rdPtr + 1'b1;
        end
        if (push && !pop) begin
            next_st.count = st.count + 1'b1;
        end else if (pop && !push) begin
            next_st.count = st.count - 1'b1;
        end
        next_st.notFull = (next_st.count != FULL_CNT);
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            st <= RST_ST;
        end else begin
            st <= next_st;
        end
    end

    assign q.inReady  = st.notFull;
    assign q.outValid = (st.count != '0);
    assign q.outData  = st.mem[st.rdPtr];
endmodule : pcds_fifo
`default_nettype wire

/* pcds_top.sv */
// column data shifter: pair buffer, two shift chains, hold stages, line gating
`timescale 1ns/10ps
`default_nettype none
module pcds_top (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        shiftClk,
    input  wire logic        serial_in_odd,
    input  wire logic        serial_in_even,
    input  wire logic        transferGate,
    input  wire logic        forceOn,
    input  wire logic        outputPermit,
    output var  logic        pairReady,
    output var  logic        cascade_out_odd,
    output var  logic        cascade_out_even,
    output var  logic [31:0] line_drive
);
    typedef struct packed {
        logic        clkPrev;
        logic [31:0] shift_stage;
        logic [31:0] hold_stage;
        logic [31:0] lineOut;
    } pcds_state_s;

    pcds_state_s st;
    pcds_state_s next_st;
    logic        shiftFall;
    logic        shiftPop;
    logic [31:0] stageIn;

    pcds_fifo_if #(.WIDTH(pcds_pkg::PAIR_W)) fq ();

    //--------------------------------------------------------
    // pair capture on falling shift clock
    //--------------------------------------------------------
    assign shiftFall  = st.clkPrev & ~shiftClk;
    assign fq.inValid = shiftFall;
    assign fq.inData  = {serial_in_even, serial_in_odd};
    // a queued pair moves into the chains on the next edge, gate or not
    assign fq.outReady = 1'b1;
    assign shiftPop    = fq.outValid & fq.outReady;

    pcds_fifo #(
        .WIDTH (pcds_pkg::PAIR_W),
        .DEPTH (pcds_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk  (ref_clk),
        .rstN (nrst),
        .q    (fq)
    );

    //--------------------------------------------------------
    // chain inputs per stage
    //--------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < pcds_pkg::NUM_LINES; gi++) begin : g_stage
            if (gi == pcds_pkg::ODD_BIT) begin : g_odd_head
                assign stageIn[gi] = fq.outData[pcds_pkg::ODD_BIT];
            end else if (gi == pcds_pkg::EVEN_BIT) begin : g_even_head
                assign stageIn[gi] = fq.outData[pcds_pkg::EVEN_BIT];
            end else begin : g_body
                assign stageIn[gi] = st.shift_stage[gi - pcds_pkg::CHAIN_STEP];
            end
        end
    endgenerate

    //--------------------------------------------------------
    // next state
    //--------------------------------------------------------
    always_comb begin
        next_st         = st;
        next_st.clkPrev = shiftClk;
        if (shiftPop) begin
            next_st.shift_stage = stageIn;
        end
        if (transferGate) begin
            next_st.hold_stage = st.shift_stage;
        end
        if (!outputPermit) begin
            next_st.lineOut = pcds_pkg::LINES_OFF;
        end else if (forceOn) begin
            next_st.lineOut = pcds_pkg::LINES_ON;
        end else begin
            next_st.lineOut = next_st.hold_stage;
        end
    end

    // stages are cleared at reset only to give a defined start
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st.clkPrev     <= 1'b0;
            st.shift_stage <= pcds_pkg::STAGE_RST;
            st.hold_stage  <= pcds_pkg::STAGE_RST;
            st.lineOut     <= pcds_pkg::LINES_OFF;
        end else begin
            st <= next_st;
        end
    end

    //--------------------------------------------------------
    // outputs
    //--------------------------------------------------------
    assign pairReady        = fq.inReady;
    assign cascade_out_odd  = st.shift_stage[pcds_pkg::LAST_ODD];
    assign cascade_out_even = st.shift_stage[pcds_pkg::LAST_EVEN];
    assign line_drive       = st.lineOut;

    //--------------------------------------------------------
    // assertions
    //--------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    property p_both_chains;
        shiftPop |=> (st.shift_stage[29:2] == $past(st.shift_stage[27:0]));
    endproperty
    a_both_chains: assert property (p_both_chains) else $error("chains did not shift together");

    property p_even_chain;
        shiftPop |=> (st.shift_stage[1] == $past(fq.outData[1]))
                     && (st.shift_stage[31] == $past(st.shift_stage[29]));
    endproperty
    a_even_chain: assert property (p_even_chain) else $error("even chain wrong");

    property p_odd_chain;
        shiftPop |=> (st.shift_stage[0] == $past(fq.outData[0]))
                     && (st.shift_stage[30] == $past(st.shift_stage[28]));
    endproperty
    a_odd_chain: assert property (p_odd_chain) else $error("odd chain wrong");

    property p_no_shift;
        !shiftPop |=> $stable(st.shift_stage);
    endproperty
    a_no_shift: assert property (p_no_shift) else $error("stage changed without shift");

    property p_transparent;
        transferGate |=> (st.hold_stage == $past(st.shift_stage));
    endproperty
    a_transparent: assert property (p_transparent) else $error("hold stage not transparent");

    property p_hold;
        !transferGate |=> $stable(st.hold_stage);
    endproperty
    a_hold: assert property (p_hold) else $error("hold stage changed while gate low");

    property p_force;
        (outputPermit && forceOn) |=> (line_drive == pcds_pkg::LINES_ON);
    endproperty
    a_force: assert property (p_force) else $error("lines not all on under force");

    property p_follow;
        (outputPermit && !forceOn) |=> (line_drive == st.hold_stage);
    endproperty
    a_follow: assert property (p_follow) else $error("lines do not follow hold stages");

    property p_off;
        !outputPermit |=> (line_drive == pcds_pkg::LINES_OFF);
    endproperty
    a_off: assert property (p_off) else $error("lines not off without permit");

    property p_cascade;
        shiftPop |=> (cascade_out_odd == $past(st.shift_stage[28]))
                     && (cascade_out_even == $past(st.shift_stage[29]));
    endproperty
    a_cascade: assert property (p_cascade) else $error("cascade outputs wrong");

    //--------------------------------------------------------
    // assertions: pair capture
    //--------------------------------------------------------
    property p_pair_taken;
        shiftFall |=> fq.outValid && (fq.outData == $past(fq.inData));
    endproperty
    a_pair_taken: assert property (p_pair_taken) else $error("pair not captured");

    property p_one_step;
        shiftPop |=> !shiftPop;
    endproperty
    a_one_step: assert property (p_one_step) else $error("double step");

    property p_need_fall;
        shiftPop |-> $past(shiftFall);
    endproperty
    a_need_fall: assert property (p_need_fall) else $error("shift without fall");

    property p_drain;
        fq.outValid |-> shiftPop;
    endproperty
    a_drain: assert property (p_drain) else $error("queued pair not shifted");

    property p_no_drop;
        pairReady;
    endproperty
    a_no_drop: assert property (p_no_drop) else $error("pair buffer full");

    //--------------------------------------------------------
    // assertions: hold stages and cascade
    //--------------------------------------------------------
    property p_gate_to_line;
        (transferGate && outputPermit && !forceOn) |=> (line_drive == $past(st.shift_stage));
    endproperty
    a_gate_to_line: assert property (p_gate_to_line) else $error("line not passed");

    property p_hold_shift;
        (!transferGate && shiftPop) |=> (st.hold_stage == $past(st.hold_stage));
    endproperty
    a_hold_shift: assert property (p_hold_shift) else $error("hold moved");

    property p_cascade_still;
        !shiftPop |=> $stable({cascade_out_even, cascade_out_odd});
    endproperty
    a_cascade_still: assert property (p_cascade_still) else $error("cascade moved");

    //--------------------------------------------------------
    // covers
    //--------------------------------------------------------
    c_shift: cover property (shiftPop ##1 shiftPop);
    c_transfer: cover property (transferGate ##1 !transferGate);
    c_gate_shift: cover property (transferGate && shiftPop);
    c_force: cover property ((outputPermit && forceOn) ##1 (outputPermit && !forceOn));
    c_permit_off: cover property ((outputPermit && !forceOn) ##1 !outputPermit);
endmodule : pcds_top
`default_nettype wire

/* pcds_ctrl_model.sv */
// display controller model: sends one line word as sixteen serial bit pairs
`timescale 1ns/10ps
`default_nettype none
module pcds_ctrl_model (
    input  wire logic        ref_clk,
    input  wire logic        start,
    input  wire logic [31:0] word,
    output var  logic        shiftClk,
    output var  logic        serOdd,
    output var  logic        serEven,
    output var  logic        busy
);
    initial begin
        shiftClk = 1'b1;
        serOdd   = 1'b0;
        serEven  = 1'b0;
        busy     = 1'b0;
        forever begin
            @(posedge ref_clk);
            if (start) begin
                busy <= 1'b1;
                for (int k = 0; k < 16; k++) begin
                    shiftClk <= 1'b1;
                    serOdd   <= ~serOdd;
                    serEven  <= ~serEven;
                    @(posedge ref_clk);
                    shiftClk <= 1'b0;
                    serOdd   <= word[30-2*k];
                    serEven  <= word[31-2*k];
                    @(posedge ref_clk);
                end
                shiftClk <= 1'b1;
                serOdd   <= ~serOdd;
                serEven  <= ~serEven;
                busy     <= 1'b0;
            end
        end
    end
endmodule : pcds_ctrl_model
`default_nettype wire

/* plasma_column_data_shifter_tb.sv */
// self-checking bench for the column data shifter
`timescale 1ns/10ps
`default_nettype none
module plasma_column_data_shifter_tb;
    typedef struct {logic [1:0] kind; logic [31:0] val;} pcds_note_s;
    logic        ref_clk, nrst, shiftClk, serOdd, serEven, transferGate, forceOn;
    logic        outputPermit, pairReady, cascOdd, cascEven, start, busy, chkReq;
    logic [31:0] lineDrive, word, s, v;
    logic [31:0] lineDrive2;
    int          err_total = 0;
    int          check_count = 0;
    pcds_note_s  notes[$];
    pcds_note_s  n;

    pcds_top i_pcds_top (.ref_clk(ref_clk), .nrst(nrst), .shiftClk(shiftClk),
        .serial_in_odd(serOdd), .serial_in_even(serEven), .transferGate(transferGate),
        .forceOn(forceOn), .outputPermit(outputPermit), .pairReady(pairReady),
        .cascade_out_odd(cascOdd), .cascade_out_even(cascEven), .line_drive(lineDrive));
    pcds_ctrl_model i_pcds_ctrl_model (.ref_clk(ref_clk), .start(start), .word(word),
        .shiftClk(shiftClk), .serOdd(serOdd), .serEven(serEven), .busy(busy));
    // second device fed from the first one's cascade outputs, same clocks
    pcds_top i_pcds_top_chain (.ref_clk(ref_clk), .nrst(nrst), .shiftClk(shiftClk),
        .serial_in_odd(cascOdd), .serial_in_even(cascEven), .transferGate(transferGate),
        .forceOn(forceOn), .outputPermit(outputPermit), .pairReady(),
        .cascade_out_odd(), .cascade_out_even(), .line_drive(lineDrive2));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task test_done;
        if (err_total == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done

    task report(input logic [31:0] a, input logic [31:0] e);
        check_count++;
        if (a !== e) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, a, e);
        end
    endtask : report
    task cmp_lines(input logic [31:0] a, input logic [31:0] e); report(a, e); endtask : cmp_lines
    task cmp_casc(input logic [1:0] a, input logic [1:0] e); report({30'h0, a}, {30'h0, e}); endtask : cmp_casc
    task cmp_flag(input logic a, input logic e); report({31'h0, a}, {31'h0, e}); endtask : cmp_flag

    task note(input logic [1:0] k, input logic [31:0] x);
        notes.push_back('{k, x});
        chkReq <= 1'b1;
        @(posedge ref_clk);
        chkReq <= 1'b0;
        @(posedge ref_clk);
    endtask : note

    task send(input logic [31:0] w);
        int t;
        word  <= w;
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        @(posedge ref_clk);
        t = 0;
        while (busy === 1'b1 && t < 200) begin
            @(posedge ref_clk);
            t++;
        end
        if (t >= 200) err_total++;
        repeat (4) @(posedge ref_clk);
    endtask : send

    task latch;
        transferGate <= 1'b1;
        repeat (2) @(posedge ref_clk);
        transferGate <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask : latch

    // monitor: compares each noted result against the outputs
    always @(negedge ref_clk) begin
        if (chkReq === 1'b1 && notes.size() > 0) begin
            n = notes.pop_front();
            case (n.kind)
                2'h0: cmp_lines(lineDrive, n.val);
                2'h1: cmp_casc({cascEven, cascOdd}, n.val[1:0]);
                2'h3: cmp_lines(lineDrive2, n.val);
                default: cmp_flag(pairReady, n.val[0]);
            endcase
        end
    end

    initial begin
        #2000000;
        err_total++;
        test_done();
    end

    initial begin
        nrst = 1'b0; transferGate = 1'b0; forceOn = 1'b0; outputPermit = 1'b1;
        start = 1'b0; word = 32'h0; chkReq = 1'b0; s = 32'h0;
        void'($urandom(97));
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        note(2'h2, 32'h1);
        for (int r = 0; r < 4; r++) begin
            v = $urandom;
            send(v);
            note(2'h1, {30'h0, v[31], v[30]});
            if (r > 0) note(2'h0, s);
            latch();
            note(2'h0, v);
            if (r > 0) note(2'h3, s);
            s = v;
        end
        for (int m = 0; m < 4; m++) begin
            outputPermit <= m[1];
            forceOn      <= m[0];
            repeat (3) @(posedge ref_clk);
            note(2'h0, !m[1] ? 32'h0 : (m[0] ? 32'hffffffff : s));
            note(2'h1, {30'h0, s[31], s[30]});
        end
        outputPermit <= 1'b1;
        forceOn      <= 1'b0;
        transferGate <= 1'b1;
        v = $urandom;
        send(v);
        note(2'h2, 32'h1);
        note(2'h0, v);
        note(2'h3, s);
        transferGate <= 1'b0;
        forceOn      <= 1'b1;
        outputPermit <= 1'b0;
        repeat (12) @(posedge ref_clk);
        outputPermit <= 1'b1;
        forceOn      <= 1'b0;
        repeat (2) @(posedge ref_clk);
        note(2'h1, {30'h0, v[31], v[30]});
        note(2'h0, v);
        s = v;
        v = $urandom;
        send(v);
        note(2'h0, s);
        note(2'h1, {30'h0, v[31], v[30]});
        latch();
        note(2'h0, v);
        note(2'h3, s);
        test_done();
    end
endmodule : plasma_column_data_shifter_tb
`default_nettype wire
